// ===== hdlc_unit.sv
// HDLC processing unit with its transfer clock generator and an AHB-Lite register slave.
// Assumes one AHB master issuing single word transfers; the slave never inserts wait states.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`default_nettype none
module hdlc_unit
   import hdlc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic tx_irq_out,
   output logic rx_irq_out,
   output logic bt_irq_out,
   output logic transfer_clk_out
);
   ahb_req_t req_ff;
   logic [31:0] hrdata_ff;
   logic [7:0] bt_ctrl0_ff, bt_ctrl1_ff, wave_ctrl0_ff, wave_ctrl1_ff, func_sel_ff, func_en_ff;
   logic [15:0] wave_period_ff, wave_edge_ff;
   logic [7:0] mode_ff, ext_mode_ff, tx_ext_ff, rx_ext_ff, irq_sel_ff;
   logic [7:0] cmp0_ff, cmp1_ff, cmp2_ff, cmp3_ff, msk0_ff, msk1_ff;
   logic [7:0] clk_sel_ff, prescale_ff, rx_in_ff, rx_buf_ff, tx_buf_ff, tx_out_ff;
   logic [15:0] tx_crc_ff, rx_crc_ff;
   logic tx_en_ff, rx_en_ff, tx_empty_ff, shift_empty_ff, rx_done_ff, abort_ff, stuff_err_ff;
   logic tx_irq_ff, rx_irq_ff, bt_irq_ff;
   // Address phase capture and write decode.
   wire addr_take = hsel_in && htrans_in[1] && hready_in;
   wire wr_en = req_ff.valid && req_ff.write;
   wire rd_take = addr_take && !hwrite_in;
   wire [7:0] wr_addr = req_ff.addr;
   wire [7:0] wd8 = hwdata_in[7:0];
   wire wr_bt0 = wr_en && wr_addr == OFF_BT_CTRL0;
   wire wr_bt1 = wr_en && wr_addr == OFF_BT_CTRL1;
   wire wr_wc0 = wr_en && wr_addr == OFF_WAVE_CTRL0;
   wire wr_wc1 = wr_en && wr_addr == OFF_WAVE_CTRL1;
   wire wr_per = wr_en && wr_addr == OFF_WAVE_PERIOD;
   wire wr_edg = wr_en && wr_addr == OFF_WAVE_EDGE;
   wire wr_fs = wr_en && wr_addr == OFF_FUNC_SEL;
   wire wr_fe = wr_en && wr_addr == OFF_FUNC_EN;
   wire wr_mode = wr_en && wr_addr == OFF_MODE;
   wire wr_emode = wr_en && wr_addr == OFF_EXT_MODE;
   wire wr_ctl = wr_en && wr_addr == OFF_CONTROL;
   wire wr_txe = wr_en && wr_addr == OFF_TX_EXT;
   wire wr_rxe = wr_en && wr_addr == OFF_RX_EXT;
   wire wr_irf = wr_en && wr_addr == OFF_IRQ_FLAG;
   wire wr_c0 = wr_en && wr_addr == OFF_CMP0;
   wire wr_c1 = wr_en && wr_addr == OFF_CMP1;
   wire wr_c2 = wr_en && wr_addr == OFF_CMP2;
   wire wr_c3 = wr_en && wr_addr == OFF_CMP3;
   wire wr_m0 = wr_en && wr_addr == OFF_MSK0;
   wire wr_m1 = wr_en && wr_addr == OFF_MSK1;
   wire wr_rxin = wr_en && wr_addr == OFF_RX_IN;
   wire wr_txb = wr_en && wr_addr == OFF_TX_BUF;
   wire wr_cs = wr_en && wr_addr == OFF_CLK_SEL;
   wire wr_ps = wr_en && wr_addr == OFF_PRESCALE;
   wire rd_rxbuf = rd_take && haddr_in[7:0] == OFF_RX_BUF;
   // Clock sources.
   logic [4:0] pre_cnt_ff;
   logic [2:0] f8_cnt_ff;
   logic [5:0] bt_cnt_ff;
   logic [16:0] wave_cnt_ff;
   logic wave_ff;
   wire [3:0] pre_n = prescale_ff[3:0];
   wire [4:0] pre_last = 5'({pre_n, 1'b0} - 5'h01);
   wire f2n_tick = (pre_n == 4'h0) || (pre_cnt_ff == pre_last);
   wire f8_tick = f8_cnt_ff == F8_LAST;
   wire bt_src_tick = (bt_ctrl0_ff[BT0_SRC_LO +: 2] == 2'b00) ? 1'b1 : f2n_tick;
   wire [4:0] bt_div = bt_ctrl0_ff[4:0];
   wire [5:0] bt_last = 6'({bt_div, 1'b0} - 6'h01);
   wire fbt_tick = bt_src_tick && ((bt_div == 5'h00) || (bt_cnt_ff == bt_last));
   wire wave_on = bt_ctrl1_ff == BT_CTRL1_SINGLE_PHASE && func_sel_ff[1:0] == 2'b00
                  && func_en_ff[1:0] == 2'b11;
   // The last count is twice the period plus 3, so it fits in 17 bits only for periods up to 0xFFFE.
   wire [16:0] wave_last = 17'({1'b0, wave_period_ff, 1'b0} + 18'h00003);
   wire wave_rise = wave_on && fbt_tick && wave_cnt_ff == {1'b0, wave_edge_ff};
   wire [3:0] tick_by_sel = {f8_tick, f2n_tick, 1'b1, wave_rise};
   wire bit_tick = tick_by_sel[clk_sel_ff[CLK_U1_HI:CLK_U1_LO]];
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         pre_cnt_ff <= 5'h00;
         f8_cnt_ff <= 3'h0;
         bt_cnt_ff <= 6'h00;
         wave_cnt_ff <= 17'h00000;
         wave_ff <= 1'b0;
      end
      else
      begin
         pre_cnt_ff <= f2n_tick ? 5'h00 : 5'(pre_cnt_ff + 5'h01);
         f8_cnt_ff <= 3'(f8_cnt_ff + 3'h1);
         if (bt_src_tick)
            bt_cnt_ff <= fbt_tick ? 6'h00 : 6'(bt_cnt_ff + 6'h01);
         if (!wave_on)
         begin
            wave_cnt_ff <= 17'h00000;
            wave_ff <= 1'b0;
         end
         else if (fbt_tick)
         begin
            wave_cnt_ff <= (wave_cnt_ff == wave_last) ? 17'h00000 : 17'(wave_cnt_ff + 17'h00001);
            if (wave_cnt_ff == wave_last)
               wave_ff <= 1'b0;
            else if (wave_rise)
               wave_ff <= 1'b1;
         end
      end
   end
   // Transmit path: buffer, shift, stuffing, CRC and output assembly.
   tx_state_t tx_state_ff;
   logic [7:0] tx_sr_ff, tx_asm_ff;
   logic [3:0] tx_bits_ff, tx_asm_cnt_ff;
   logic [2:0] tx_ones_ff;
   wire tx_stuff_en = tx_ext_ff[TXE_STUFF_LO +: 2] != 2'b00;
   wire tx_step = tx_state_ff == TX_SHIFT && bit_tick;
   wire tx_insert = tx_stuff_en && tx_ones_ff == STUFF_RUN;
   wire tx_bit = tx_insert ? 1'b0 : tx_sr_ff[0];
   wire tx_last = tx_step && !tx_insert && tx_bits_ff == 4'h7;
   wire tx_load = tx_en_ff && !tx_empty_ff && (tx_state_ff == TX_IDLE || tx_last);
   wire [15:0] tx_crc_sh = {tx_crc_ff[14:0], 1'b0};
   wire [15:0] tx_crc_nx = (tx_bit ^ tx_crc_ff[15]) ? (tx_crc_sh ^ CRC_POLY) : tx_crc_sh;
   wire [7:0] tx_asm_nx = {tx_bit, tx_asm_ff[7:1]};
   wire tx_asm_full = tx_step && tx_asm_cnt_ff == 4'h7;
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         tx_state_ff <= TX_IDLE;
         tx_sr_ff <= REG8_RST;
         tx_asm_ff <= REG8_RST;
         tx_bits_ff <= 4'h0;
         tx_asm_cnt_ff <= 4'h0;
         tx_ones_ff <= 3'h0;
         tx_crc_ff <= CRC_INIT;
         tx_out_ff <= REG8_RST;
      end
      else
      begin
         if (tx_load)
         begin
            tx_state_ff <= TX_SHIFT;
            tx_sr_ff <= tx_buf_ff;
            tx_bits_ff <= 4'h0;
         end
         else if (tx_last)
            tx_state_ff <= TX_IDLE;
         if (tx_step)
         begin
            if (!tx_insert && !tx_load)
            begin
               tx_sr_ff <= {1'b0, tx_sr_ff[7:1]};
               tx_bits_ff <= 4'(tx_bits_ff + 4'h1);
            end
            tx_ones_ff <= tx_bit ? 3'(tx_ones_ff + 3'h1) : 3'h0;
            tx_asm_ff <= tx_asm_nx;
            tx_asm_cnt_ff <= tx_asm_full ? 4'h0 : 4'(tx_asm_cnt_ff + 4'h1);
            if (tx_asm_full)
               tx_out_ff <= tx_asm_nx;
            if (tx_ext_ff[TXE_CRC_EN] && !tx_insert)
               tx_crc_ff <= tx_crc_nx;
         end
         if (!tx_en_ff)
            tx_crc_ff <= CRC_INIT;
      end
   end
   // Receive path: input register, destuffing, CRC and byte assembly.
   rx_state_t rx_state_ff;
   logic [7:0] rx_sr_ff, rx_asm_ff;
   logic [3:0] rx_bits_ff, rx_asm_cnt_ff;
   logic [2:0] rx_ones_ff;
   wire rx_stuff_en = rx_ext_ff[RXE_STUFF_LO +: 2] != 2'b00;
   wire rx_step = rx_state_ff == RX_SHIFT && bit_tick && rx_ext_ff[RXE_SHIFT_EN];
   wire rx_bit = rx_sr_ff[0];
   wire rx_drop = rx_stuff_en && rx_ones_ff == STUFF_RUN && !rx_bit;
   wire rx_keep = rx_step && !rx_drop;
   wire [7:0] rx_asm_nx = {rx_bit, rx_asm_ff[7:1]};
   wire rx_full = rx_keep && rx_asm_cnt_ff == 4'h7;
   wire [15:0] rx_crc_sh = {rx_crc_ff[14:0], 1'b0};
   wire [15:0] rx_crc_nx = (rx_bit ^ rx_crc_ff[15]) ? (rx_crc_sh ^ CRC_POLY) : rx_crc_sh;
   wire rx_start = wr_rxin && rx_en_ff;
   wire [7:0] rx_byte = rx_asm_nx;
   rx_evt_t rx_evt;
   assign rx_evt.rx_done = rx_full;
   assign rx_evt.cmp_hit[0] = rx_full && rx_ext_ff[0] && ((rx_byte ^ cmp0_ff) & ~msk0_ff) == 8'h00;
   assign rx_evt.cmp_hit[1] = rx_full && rx_ext_ff[1] && ((rx_byte ^ cmp1_ff) & ~msk1_ff) == 8'h00;
   assign rx_evt.cmp_hit[2] = rx_full && rx_ext_ff[2] && rx_byte == cmp2_ff;
   assign rx_evt.cmp_hit[3] = rx_full && rx_ext_ff[RXE_FLAG_CMP] && rx_byte == cmp3_ff;
   assign rx_evt.abort = rx_evt.cmp_hit[0] || rx_evt.cmp_hit[1];
   assign rx_evt.stuff_err = rx_step && rx_stuff_en && rx_bit && rx_ones_ff == ERR_RUN - 3'h1;
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rx_state_ff <= RX_IDLE;
         rx_sr_ff <= REG8_RST;
         rx_asm_ff <= REG8_RST;
         rx_bits_ff <= 4'h0;
         rx_asm_cnt_ff <= 4'h0;
         rx_ones_ff <= 3'h0;
         rx_crc_ff <= CRC_INIT;
         rx_buf_ff <= REG8_RST;
      end
      else
      begin
         if (rx_start)
         begin
            rx_state_ff <= RX_SHIFT;
            rx_sr_ff <= wd8;
            rx_bits_ff <= 4'h0;
         end
         else if (rx_step)
         begin
            rx_sr_ff <= {1'b0, rx_sr_ff[7:1]};
            rx_bits_ff <= 4'(rx_bits_ff + 4'h1);
            if (rx_bits_ff == 4'h7)
               rx_state_ff <= RX_IDLE;
         end
         if (rx_step)
            rx_ones_ff <= rx_bit ? ((rx_ones_ff == ERR_RUN) ? ERR_RUN : 3'(rx_ones_ff + 3'h1)) : 3'h0;
         if (rx_keep)
         begin
            rx_asm_ff <= rx_asm_nx;
            rx_asm_cnt_ff <= rx_full ? 4'h0 : 4'(rx_asm_cnt_ff + 4'h1);
            if (rx_ext_ff[RXE_CRC_EN])
               rx_crc_ff <= rx_crc_nx;
         end
         if (rx_full)
            rx_buf_ff <= rx_byte;
         if (rx_evt.cmp_hit[3])
            rx_crc_ff <= CRC_INIT;
      end
   end
   // Interrupt request selection.
   wire [15:0] rx_cause_vec = {9'h000, rx_evt.stuff_err, rx_evt.abort, rx_evt.cmp_hit, rx_evt.rx_done};
   wire rx_irq_nx = rx_cause_vec[irq_sel_ff[3:0]];
   wire tx_irq_nx = mode_ff[MODE_IRS] ? tx_last : tx_load;
   wire bt_irq_nx = bt_ctrl0_ff[5] ? wave_rise : (wave_on && fbt_tick && wave_cnt_ff == wave_last);
   // Register file.
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         req_ff <= '0;
         {bt_ctrl0_ff, bt_ctrl1_ff, wave_ctrl0_ff, wave_ctrl1_ff} <= {4{REG8_RST}};
         {func_sel_ff, func_en_ff, mode_ff, ext_mode_ff} <= {4{REG8_RST}};
         {tx_ext_ff, rx_ext_ff, irq_sel_ff, clk_sel_ff, prescale_ff} <= {5{REG8_RST}};
         {cmp0_ff, cmp1_ff, cmp2_ff, cmp3_ff, msk0_ff, msk1_ff} <= {6{REG8_RST}};
         {wave_period_ff, wave_edge_ff} <= {2{REG16_RST}};
         {rx_in_ff, tx_buf_ff} <= {2{REG8_RST}};
         {tx_en_ff, rx_en_ff, rx_done_ff, abort_ff, stuff_err_ff} <= 5'h00;
         {tx_empty_ff, shift_empty_ff} <= 2'h3;
         {tx_irq_ff, rx_irq_ff, bt_irq_ff} <= 3'h0;
      end
      else
      begin
         req_ff <= '{valid: addr_take, write: hwrite_in, addr: haddr_in[7:0]};
         if (wr_bt0) bt_ctrl0_ff <= wd8;
         if (wr_bt1) bt_ctrl1_ff <= wd8;
         if (wr_wc0) wave_ctrl0_ff <= wd8;
         if (wr_wc1) wave_ctrl1_ff <= wd8;
         if (wr_per) wave_period_ff <= hwdata_in[15:0];
         if (wr_edg) wave_edge_ff <= hwdata_in[15:0];
         if (wr_fs) func_sel_ff <= wd8;
         if (wr_fe) func_en_ff <= wd8;
         if (wr_mode) mode_ff <= wd8;
         if (wr_emode) ext_mode_ff <= wd8;
         if (wr_txe) tx_ext_ff <= wd8 & 8'hD8;
         if (wr_rxe) rx_ext_ff <= wd8;
         if (wr_irf) irq_sel_ff <= {4'h0, wd8[3:0]};
         if (wr_c0) cmp0_ff <= wd8;
         if (wr_c1) cmp1_ff <= wd8;
         if (wr_c2) cmp2_ff <= wd8;
         if (wr_c3) cmp3_ff <= wd8;
         if (wr_m0) msk0_ff <= wd8;
         if (wr_m1) msk1_ff <= wd8;
         if (wr_rxin) rx_in_ff <= wd8;
         if (wr_cs) clk_sel_ff <= wd8;
         if (wr_ps) prescale_ff <= wd8;
         if (wr_ctl)
         begin
            tx_en_ff <= hwdata_in[CTL_TX_EN];
            rx_en_ff <= hwdata_in[CTL_RX_EN];
         end
         if (wr_txb)
            tx_buf_ff <= wd8;
         else if (rx_full)
            tx_buf_ff <= rx_byte;
         if (wr_txb)
            tx_empty_ff <= 1'b0;
         else if (tx_load)
            tx_empty_ff <= 1'b1;
         if (tx_load)
            shift_empty_ff <= 1'b0;
         else if (tx_last)
            shift_empty_ff <= 1'b1;
         if (rx_full)
            rx_done_ff <= 1'b1;
         else if (rd_rxbuf)
            rx_done_ff <= 1'b0;
         if (rx_evt.abort)
            abort_ff <= 1'b1;
         else if (wr_irf && !wd8[IRF_ABORT])
            abort_ff <= 1'b0;
         if (rx_evt.stuff_err)
            stuff_err_ff <= 1'b1;
         else if (wr_irf && !wd8[IRF_STUFF_ERR])
            stuff_err_ff <= 1'b0;
         tx_irq_ff <= tx_irq_nx;
         rx_irq_ff <= rx_irq_nx;
         bt_irq_ff <= bt_irq_nx;
      end
   end
   // Read mux, sampled in the address phase so data stands in the data phase.
   logic [31:0] rd_mux;
   wire [7:0] ctl_rd = {2'b00, shift_empty_ff, 1'b0, rx_done_ff, rx_en_ff, tx_empty_ff, tx_en_ff};
   wire [7:0] irf_rd = {2'b00, abort_ff, stuff_err_ff, irq_sel_ff[3:0]};
   always_comb
   begin
      case (haddr_in[7:0])
         OFF_BT_CTRL0: rd_mux = {24'h000000, bt_ctrl0_ff};
         OFF_BT_CTRL1: rd_mux = {24'h000000, bt_ctrl1_ff};
         OFF_WAVE_CTRL0: rd_mux = {24'h000000, wave_ctrl0_ff};
         OFF_WAVE_CTRL1: rd_mux = {24'h000000, wave_ctrl1_ff};
         OFF_WAVE_PERIOD: rd_mux = {16'h0000, wave_period_ff};
         OFF_WAVE_EDGE: rd_mux = {16'h0000, wave_edge_ff};
         OFF_FUNC_SEL: rd_mux = {24'h000000, func_sel_ff};
         OFF_FUNC_EN: rd_mux = {24'h000000, func_en_ff};
         OFF_MODE: rd_mux = {24'h000000, mode_ff};
         OFF_EXT_MODE: rd_mux = {24'h000000, ext_mode_ff};
         OFF_CONTROL: rd_mux = {24'h000000, ctl_rd};
         OFF_TX_EXT: rd_mux = {24'h000000, tx_ext_ff};
         OFF_RX_EXT: rd_mux = {24'h000000, rx_ext_ff};
         OFF_IRQ_FLAG: rd_mux = {24'h000000, irf_rd};
         OFF_CMP0: rd_mux = {24'h000000, cmp0_ff};
         OFF_CMP1: rd_mux = {24'h000000, cmp1_ff};
         OFF_CMP2: rd_mux = {24'h000000, cmp2_ff};
         OFF_CMP3: rd_mux = {24'h000000, cmp3_ff};
         OFF_MSK0: rd_mux = {24'h000000, msk0_ff};
         OFF_MSK1: rd_mux = {24'h000000, msk1_ff};
         OFF_TX_CRC: rd_mux = {16'h0000, tx_crc_ff};
         OFF_RX_CRC: rd_mux = {16'h0000, rx_crc_ff};
         OFF_TX_OUT: rd_mux = {24'h000000, tx_out_ff};
         OFF_RX_IN: rd_mux = {24'h000000, rx_in_ff};
         OFF_RX_BUF: rd_mux = {24'h000000, rx_buf_ff};
         OFF_TX_BUF: rd_mux = {24'h000000, tx_buf_ff};
         OFF_CLK_SEL: rd_mux = {24'h000000, clk_sel_ff};
         OFF_PRESCALE: rd_mux = {24'h000000, prescale_ff};
         default: rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         hrdata_ff <= 32'h00000000;
      else if (rd_take)
         hrdata_ff <= rd_mux;
   end
   assign hrdata_out = hrdata_ff;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign tx_irq_out = tx_irq_ff;
   assign rx_irq_out = rx_irq_ff;
   assign bt_irq_out = bt_irq_ff;
   assign transfer_clk_out = wave_ff;
endmodule
`default_nettype wire

// ===== hdlc_pkg.sv
// Package for the HDLC processing unit: register offsets, field positions, reset values and types.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
`default_nettype none
package hdlc_pkg;
   localparam logic [7:0] OFF_BT_CTRL0 = 8'h00;
   localparam logic [7:0] OFF_BT_CTRL1 = 8'h04;
   localparam logic [7:0] OFF_WAVE_CTRL0 = 8'h08;
   localparam logic [7:0] OFF_WAVE_CTRL1 = 8'h0C;
   localparam logic [7:0] OFF_WAVE_PERIOD = 8'h10;
   localparam logic [7:0] OFF_WAVE_EDGE = 8'h14;
   localparam logic [7:0] OFF_FUNC_SEL = 8'h18;
   localparam logic [7:0] OFF_FUNC_EN = 8'h1C;
   localparam logic [7:0] OFF_MODE = 8'h20;
   localparam logic [7:0] OFF_EXT_MODE = 8'h24;
   localparam logic [7:0] OFF_CONTROL = 8'h28;
   localparam logic [7:0] OFF_TX_EXT = 8'h2C;
   localparam logic [7:0] OFF_RX_EXT = 8'h30;
   localparam logic [7:0] OFF_IRQ_FLAG = 8'h34;
   localparam logic [7:0] OFF_CMP0 = 8'h38;
   localparam logic [7:0] OFF_CMP1 = 8'h3C;
   localparam logic [7:0] OFF_CMP2 = 8'h40;
   localparam logic [7:0] OFF_CMP3 = 8'h44;
   localparam logic [7:0] OFF_MSK0 = 8'h48;
   localparam logic [7:0] OFF_MSK1 = 8'h4C;
   localparam logic [7:0] OFF_TX_CRC = 8'h50;
   localparam logic [7:0] OFF_RX_CRC = 8'h54;
   localparam logic [7:0] OFF_TX_OUT = 8'h58;
   localparam logic [7:0] OFF_RX_IN = 8'h5C;
   localparam logic [7:0] OFF_RX_BUF = 8'h60;
   localparam logic [7:0] OFF_TX_BUF = 8'h64;
   localparam logic [7:0] OFF_CLK_SEL = 8'h68;
   localparam logic [7:0] OFF_PRESCALE = 8'h6C;
   // Field positions.
   localparam int CTL_TX_EN = 0;
   localparam int CTL_TX_EMPTY = 1;
   localparam int CTL_RX_EN = 2;
   localparam int CTL_RX_DONE = 3;
   localparam int CTL_SHIFT_EMPTY = 5;
   localparam int MODE_IRS = 4;
   localparam int TXE_CRC_EN = 3;
   localparam int TXE_STUFF_LO = 6;
   localparam int RXE_FLAG_CMP = 3;
   localparam int RXE_CRC_EN = 4;
   localparam int RXE_SHIFT_EN = 5;
   localparam int RXE_STUFF_LO = 6;
   localparam int IRF_STUFF_ERR = 4;
   localparam int IRF_ABORT = 5;
   localparam int CLK_U1_LO = 2;
   localparam int CLK_U1_HI = 3;
   localparam int BT0_SRC_LO = 6;
   // Reset values and constants.
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [7:0] BT_CTRL1_SINGLE_PHASE = 8'h12;
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [2:0] STUFF_RUN = 3'h5;
   localparam logic [2:0] ERR_RUN = 3'h7;
   localparam logic [2:0] F8_LAST = 3'h7;
   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } ahb_req_t;
   typedef struct packed {
      logic stuff_err;
      logic abort;
      logic [3:0] cmp_hit;
      logic rx_done;
   } rx_evt_t;
endpackage
`default_nettype wire

// ===== hdlc_unit_asserts.sv
// Port checker for hdlc_unit: bus answer, interrupt pulse shape, read data hold and transfer clock width.
// Assumes the unit answers with zero wait states and keeps every register within the low 16 bits.
`default_nettype none
module hdlc_unit_chk
   import hdlc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic tx_irq_out,
   input wire logic rx_irq_out,
   input wire logic bt_irq_out,
   input wire logic transfer_clk_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence one_cycle(s);
      s ##1 !s;
   endsequence
   sequence read_idle;
      !(hsel_in && htrans_in[1] && hready_in && !hwrite_in);
   endsequence
   AST_READY: assert property (hreadyout_out) else $error("slave inserted a wait state");
   AST_OKAY: assert property (!hresp_out) else $error("slave answered with an error");
   AST_TX_PULSE: assert property (tx_irq_out |-> one_cycle(tx_irq_out)) else $error("tx irq too long");
   AST_RX_PULSE: assert property (rx_irq_out |-> one_cycle(rx_irq_out)) else $error("rx irq too long");
   AST_BT_PULSE: assert property (bt_irq_out |-> one_cycle(bt_irq_out)) else $error("timer irq too long");
   AST_RDATA_HOLD: assert property (read_idle |=> $stable(hrdata_out))
      else $error("read data moved without a read");
   AST_UPPER_ZERO: assert property (hrdata_out[31:16] == 16'h0000) else $error("upper read bits set");
   AST_CLK_HIGH: assert property ($rose(transfer_clk_out) |-> transfer_clk_out[*4])
      else $error("transfer clock high too short");
endmodule
bind hdlc_unit hdlc_unit_chk u_hdlc_unit_chk (.clk_sys_in, .arst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
   .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .tx_irq_out, .rx_irq_out,
   .bt_irq_out, .transfer_clk_out);
`default_nettype wire

// ===== hdlc_processing_mode_setup_test.sv
// Register-level bench for hdlc_unit: reset values, transmit and receive bytes, CRC, compare and waveform clock.
// Assumes the unit is the only AHB-Lite slave, so its hreadyout is the bus hready.
`default_nettype none
module hdlc_processing_mode_setup_test
   import hdlc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic hsel_in = 1'b0;
   logic hwrite_in = 1'b0;
   logic [1:0] htrans_in = 2'h0;
   logic [31:0] haddr_in = 32'h0;
   logic [31:0] hwdata_in = 32'h0;
   wire logic [31:0] hrdata_out;
   wire logic hreadyout_out, hresp_out, tx_irq_out, rx_irq_out, bt_irq_out, transfer_clk_out;
   int bad_count = 0, n_checks = 0, ntx = 0, nrx = 0, nbt = 0, nclk = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in)
   begin
      if (tx_irq_out === 1'b1) ntx++;
      if (rx_irq_out === 1'b1) nrx++;
      if (bt_irq_out === 1'b1) nbt++;
   end
   always @(posedge transfer_clk_out) nclk++;
   hdlc_unit u_hdlc_unit (.clk_sys_in, .arst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2),
      .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .tx_irq_out, .rx_irq_out,
      .bt_irq_out, .transfer_clk_out);
   task automatic final_report;
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ready;
      int i;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_sys_in);
         if (hreadyout_out === 1'b1) break;
      end
      if (i == 20)
      begin
         bad_count++;
         $display("Error at %0t: bus wait ran out", $time);
         final_report();
      end
   endtask
   // One single transfer; the next call starts one edge later, so IDLE sits between transfers.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys_in);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in <= {24'h0, a};
      hwrite_in <= w;
      wait_ready();
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      wait_ready();
      r = hrdata_out;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      logic [31:0] r;
      for (int i = 0; i < 40; i++)
      begin
         xfer(1'b0, a, 32'h0, r);
         if ((r & m) === m) return;
      end
      bad_count++;
      $display("Error at %0t: status never set", $time);
      final_report();
   endtask
   // Serial CRC over data bits sent least significant first.
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
      for (int k = 0; k < 8; k++)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction
   initial
   begin
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      chk_rd(OFF_CONTROL, 32'h22);
      chk_rd(OFF_TX_CRC, 32'hFFFF);
      chk_rd(OFF_RX_CRC, 32'hFFFF);
      chk_rd(8'h70, 32'h0);
      wr(OFF_MODE, 32'h3);
      wr(OFF_EXT_MODE, 32'hF6);
      chk_rd(OFF_EXT_MODE, 32'hF6);
      wr(OFF_CMP2, 32'hFFFF_FFA5);
      chk_rd(OFF_CMP2, 32'hA5);
      wr(OFF_WAVE_PERIOD, 32'h1234_0001);
      chk_rd(OFF_WAVE_PERIOD, 32'h1);
      wr(OFF_CLK_SEL, 32'h4);
      wr(OFF_TX_EXT, 32'h8);
      wr(OFF_CONTROL, 32'h5);
      wr(OFF_TX_BUF, 32'hA5);
      poll(OFF_CONTROL, 32'h22);
      chk_rd(OFF_TX_OUT, 32'hA5);
      chk(32'(ntx), 32'h1);
      wr(OFF_MODE, 32'h13);
      wr(OFF_TX_BUF, 32'h3C);
      poll(OFF_CONTROL, 32'h22);
      chk_rd(OFF_TX_OUT, 32'h3C);
      chk(32'(ntx), 32'h2);
      chk_rd(OFF_TX_CRC, {16'h0, crc8(crc8(CRC_INIT, 8'hA5), 8'h3C)});
      wr(OFF_RX_EXT, 32'h10);
      wr(OFF_RX_IN, 32'h5A);
      repeat (30) @(posedge clk_sys_in);
      chk_rd(OFF_CONTROL, 32'h27);
      wr(OFF_CMP0, 32'hFE);
      wr(OFF_MSK0, 32'h01);
      wr(OFF_IRQ_FLAG, 32'h0);
      wr(OFF_RX_IN, 32'h5A);
      wr(OFF_RX_EXT, 32'h31);
      poll(OFF_CONTROL, 32'h8);
      chk_rd(OFF_TX_BUF, 32'h5A);
      chk_rd(OFF_RX_BUF, 32'h5A);
      chk_rd(OFF_RX_CRC, {16'h0, crc8(CRC_INIT, 8'h5A)});
      chk(32'(nrx), 32'h1);
      wr(OFF_IRQ_FLAG, 32'h5);
      wr(OFF_RX_IN, 32'hFF);
      poll(OFF_CONTROL, 32'h8);
      chk_rd(OFF_IRQ_FLAG, 32'h25);
      chk_rd(OFF_RX_BUF, 32'hFF);
      chk(32'(nrx), 32'h2);
      wr(OFF_CMP3, 32'h7E);
      wr(OFF_RX_EXT, 32'h39);
      wr(OFF_RX_IN, 32'h7E);
      poll(OFF_CONTROL, 32'h8);
      chk_rd(OFF_RX_CRC, 32'hFFFF);
      wr(OFF_WAVE_EDGE, 32'h1);
      wr(OFF_BT_CTRL1, {24'h0, BT_CTRL1_SINGLE_PHASE});
      wr(OFF_BT_CTRL0, 32'h20);
      wr(OFF_FUNC_EN, 32'h3);
      wr(OFF_CLK_SEL, 32'h0);
      repeat (60) @(posedge clk_sys_in);
      chk(32'(nclk >= 5), 32'h1);
      chk(32'(nbt >= 5), 32'h1);
      final_report();
   end
endmodule
`default_nettype wire
